/* rtl/edtc_pkg.sv */
/*
  Shared constants, types and helpers for the event driven transfer controller.
  Assumes a 32-bit internal bus with byte addresses and one ack per access.
*/
package edtc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // cpu-visible register offsets (byte addresses on the register port)
  localparam logic [7:0] OFF_ACT_EN = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_VBASE = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;

  // reset values
  localparam logic [15:0] RST_ACT_EN = 16'h0000;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [31:0] RST_VBASE = 32'h0000_0000;

  // control register: read skip enable
  localparam int CTRL_SKIP_BIT = 0;

  // status register fields
  localparam int STAT_BUSY_BIT = 4;
  localparam int STAT_SRC_LSB = 0;

  ////////////////////////////////////////////////////////////////////////////
  // vector table: base + 0x400 + vector number * 4
  localparam logic [31:0] VEC_TABLE_OFF = 32'h0000_0400;
  localparam logic [7:0] VEC_NUM_FIRST = 8'h40;
  localparam logic [31:0] INFO_WORD_STEP = 32'h0000_0004;
  localparam logic [1:0] INFO_LAST_WORD = 2'h3;

  // mode_a field positions
  localparam int MA_MODE_LSB = 6;
  localparam int MA_SIZE_LSB = 4;
  localparam int MA_SAM_LSB = 2;
  // mode_b field position
  localparam int MB_DAM_LSB = 2;

  // transfer modes
  localparam logic [1:0] MD_NORMAL = 2'h0;
  localparam logic [1:0] MD_REPEAT = 2'h1;
  localparam logic [1:0] MD_BLOCK = 2'h2;

  // unit sizes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;

  // address modes
  localparam logic [1:0] AM_INC = 2'h2;
  localparam logic [1:0] AM_DEC = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_GRANT = 4'h1,
    S_VEC = 4'h2,
    S_INFO = 4'h3,
    S_SRC = 4'h4,
    S_DST = 4'h5,
    S_WB = 4'h6,
    S_DONE = 4'h7
  } edtc_state_t;

  // pointer after one unit: step by unit size in the chosen direction
  function automatic logic [31:0] ptr_next(input logic [31:0] p, input logic [1:0] am,
                                           input logic [1:0] sz);
    logic [31:0] st;
    st = (sz == SZ_BYTE) ? 32'h1 : ((sz == SZ_WORD) ? 32'h2 : 32'h4);
    case (am)
      AM_INC: return p + st;
      AM_DEC: return p - st;
      default: return p;
    endcase
  endfunction : ptr_next

endpackage : edtc_pkg

/* rtl/edtc_arbiter.sv */
/*
  Request sampler and fixed-priority picker; lowest source index wins.
  Assumes requests are levels synchronous to core_clk.
*/
`timescale 1ns/1ps
module edtc_arbiter
(
  input wire logic core_clk, // system clock
  input wire logic rst_n, // synchronised reset, active low
  input wire logic ce, // clock enable
  input wire logic [15:0] req, // peripheral request levels
  input wire logic [15:0] en, // activation enables
  output logic valid_r, // some enabled request seen
  output logic [3:0] idx_r // winning source index
);
  import edtc_pkg::*;

  logic [3:0] pick;

  ////////////////////////////////////////////////////////////////////////////
  // lowest set bit wins; scan downward so the last hit is the lowest
  always_comb
  begin
    pick = 4'h0;
    for (int i = 15; i >= 0; i--)
    begin
      if (req[i] && en[i])
      begin
        pick = i[3:0];
      end
    end
  end

  // requests stay pending as levels, so nothing is lost while busy
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      valid_r <= 1'b0;
      idx_r <= 4'h0;
    end
    else if (ce)
    begin
      valid_r <= |(req & en);
      idx_r <= pick;
    end
  end

endmodule : edtc_arbiter

/* rtl/edtc_top.sv */
/*
  Event driven transfer controller: takes the internal bus on an enabled
  peripheral request, fetches its control information from on-chip RAM,
  moves data and writes the information back.
  Assumes a bus that grants mastership by level and acks each access once.
*/
// Strobed register access and the address map were chosen for this implementation.
// Functional notes
// [R1] two 8-bit mode registers inside the control information select operation
// [R2] 32-bit source pointer gives the read address of each unit
// [R3] 32-bit destination pointer gives the write address of each unit
// [R4] normal mode: first count is one 16-bit counter, 1 to 65536 transfers
// [R5] repeat mode: upper byte keeps count, lower byte runs as counter
// [R6] block mode: upper byte keeps block size, lower byte counts within block
// [R7] block mode: second 16-bit count gives number of blocks
// [R8] 16-bit enables choose which sources start a transfer
// [R9] 8-bit control register enables skipping the information read
// [R10] 32-bit vector base register anchors vector entry addresses
// [R11] hidden registers are loaded from RAM information on activation
// [R12] updated hidden registers are written back to RAM after transfer
// [R13] vector entry address is base plus 0x400 plus vector number times 4
// [R14] an enabled request that activates the controller never reaches the CPU
// [R15] take bus, read vector, read information, then move data
// [R16] step destination, write back, release bus only after writeback
// [R17] each activation moves the amount set by the size field
// [R18] converter clears its flag when its result is read by the transfer
// [R19] final transfer clears the source's enable; next request interrupts CPU
// [R20] normal, repeat and block modes selected by the mode information
// [R21] unit size is byte, word or longword
// [R22] each pointer may increment, decrement or stay fixed
// [R23] normal mode decrements the counter per transfer; zero means final
// [R24] further requests stay pending while a sequence is in progress
`timescale 1ns/1ps
module edtc_top
(
  input wire logic core_clk, // 50 MHz system clock
  input wire logic nrst, // async reset, active low
  input wire logic ce, // clock enable, freezes all state except the reset synchroniser when low
  input wire logic [7:0] reg_addr, // register byte address
  input wire logic [31:0] reg_wdata, // register write data
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  output logic [31:0] reg_rdata, // read data, cycle after reg_rd
  input wire logic [15:0] irq_in, // peripheral request levels
  output logic [15:0] cpu_irq, // requests passed on to the CPU
  output logic bm_req, // bus mastership request
  input wire logic bm_gnt, // bus mastership granted
  output logic bm_rd, // bus read, held until ack
  output logic bm_wr, // bus write, held until ack
  output logic [31:0] bm_addr, // bus address
  output logic [1:0] bm_size, // unit size of the access
  output logic [31:0] bm_wdata, // bus write data
  input wire logic [31:0] bm_rdata, // bus read data, valid with ack
  input wire logic bm_ack // access done
);
  import edtc_pkg::*;

  logic rst_s1_r;
  logic rst_n;
  edtc_state_t st_r;
  logic [1:0] idx_r;
  logic [3:0] cur_src_r;
  logic [3:0] last_src_r;
  logic info_ok_r;
  logic final_r;
  logic [31:0] info_base_r;
  logic [7:0] mode_a_r;
  logic [7:0] mode_b_r;
  logic [31:0] src_ptr_r;
  logic [31:0] dst_ptr_r;
  logic [15:0] cnt_a_r;
  logic [15:0] blk_cnt_r;
  logic [15:0] act_en_r;
  logic [7:0] ctrl_r;
  logic [31:0] vbase_r;
  logic [31:0] reg_rdata_r;
  logic [15:0] cpu_irq_r;
  logic bm_req_r;
  logic bm_rd_r;
  logic bm_wr_r;
  logic [31:0] bm_addr_r;
  logic [1:0] bm_size_r;
  logic [31:0] bm_wdata_r;
  logic arb_valid;
  logic [3:0] arb_idx;
  logic take;
  logic skip;
  logic [1:0] md;
  logic [1:0] sz;
  logic [7:0] vec_num;
  logic [31:0] vec_addr;
  logic [31:0] src_ptr_nxt;
  logic [31:0] dst_ptr_nxt;
  logic [15:0] cnt_a_nxt;
  logic [15:0] blk_cnt_nxt;
  logic block_end;
  logic last_unit;
  logic [31:0] wb_word;

  assign reg_rdata = reg_rdata_r;
  assign cpu_irq = cpu_irq_r;
  assign bm_req = bm_req_r;
  assign bm_rd = bm_rd_r;
  assign bm_wr = bm_wr_r;
  assign bm_addr = bm_addr_r;
  assign bm_size = bm_size_r;
  assign bm_wdata = bm_wdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pending requests are sampled and prioritised outside the sequencer
  edtc_arbiter u_arb
  (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .req(irq_in),
    .en(act_en_r),
    .valid_r(arb_valid),
    .idx_r(arb_idx)
  );

  // recheck live level and enable; the arbiter lags by one cycle
  assign take = (st_r == S_IDLE) && arb_valid && act_en_r[arb_idx] && irq_in[arb_idx]; // R24
  assign skip = ctrl_r[CTRL_SKIP_BIT] && info_ok_r && (last_src_r == cur_src_r); // R9
  assign vec_num = VEC_NUM_FIRST + {4'h0, cur_src_r};
  assign vec_addr = vbase_r + VEC_TABLE_OFF + {22'h0, vec_num, 2'b00}; // R13
  assign md = mode_a_r[MA_MODE_LSB +: 2]; // R20
  assign sz = mode_a_r[MA_SIZE_LSB +: 2]; // R21

  ////////////////////////////////////////////////////////////////////////////
  // next pointer and counter values after one unit
  always_comb
  begin
    src_ptr_nxt = ptr_next(src_ptr_r, mode_a_r[MA_SAM_LSB +: 2], sz); // R22
    dst_ptr_nxt = ptr_next(dst_ptr_r, mode_b_r[MB_DAM_LSB +: 2], sz); // R22
    block_end = 1'b0;
    blk_cnt_nxt = blk_cnt_r;
    cnt_a_nxt = cnt_a_r;
    last_unit = 1'b0;
    case (md)
      MD_NORMAL:
      begin
        cnt_a_nxt = cnt_a_r - 16'h1; // R4 R23
        last_unit = (cnt_a_nxt == 16'h0); // R23
      end
      MD_REPEAT:
      begin
        // lower byte reloads from the kept count; repeat never ends by itself
        cnt_a_nxt[7:0] = (cnt_a_r[7:0] == 8'h1) ? cnt_a_r[15:8] : cnt_a_r[7:0] - 8'h1; // R5
      end
      MD_BLOCK:
      begin
        block_end = (cnt_a_r[7:0] == 8'h1); // R6
        cnt_a_nxt[7:0] = block_end ? cnt_a_r[15:8] : cnt_a_r[7:0] - 8'h1; // R6
        blk_cnt_nxt = block_end ? blk_cnt_r - 16'h1 : blk_cnt_r; // R7
        last_unit = block_end && (blk_cnt_nxt == 16'h0); // R7
      end
      default:
      begin
        cnt_a_nxt = cnt_a_r;
      end
    endcase
  end

  // writeback image of the hidden registers, word by word
  always_comb
  begin
    case (idx_r + 2'h1)
      2'h1: wb_word = src_ptr_r;
      2'h2: wb_word = dst_ptr_r;
      2'h3: wb_word = {blk_cnt_r, 16'h0};
      default: wb_word = {mode_a_r, mode_b_r, cnt_a_r};
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer and bus master; strobes stay high until the bus acks
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= S_IDLE;
      idx_r <= 2'h0;
      cur_src_r <= 4'h0;
      info_base_r <= 32'h0;
      final_r <= 1'b0;
      bm_req_r <= 1'b0;
      bm_rd_r <= 1'b0;
      bm_wr_r <= 1'b0;
      bm_addr_r <= 32'h0;
      bm_size_r <= 2'h0;
      bm_wdata_r <= 32'h0;
    end
    else if (ce)
    begin
      case (st_r)
        S_IDLE:
        begin
          final_r <= 1'b0;
          if (take)
          begin
            cur_src_r <= arb_idx;
            bm_req_r <= 1'b1; // R15
            st_r <= S_GRANT;
          end
        end
        S_GRANT:
        begin
          if (bm_gnt)
          begin
            bm_rd_r <= 1'b1; // R15
            bm_addr_r <= vec_addr; // R13
            bm_size_r <= SZ_LONG;
            st_r <= S_VEC;
          end
        end
        S_VEC:
        begin
          if (bm_ack)
          begin
            info_base_r <= bm_rdata;
            idx_r <= 2'h0;
            if (skip)
            begin
              // information already held for this source; go straight to data
              bm_addr_r <= src_ptr_r; // R9
              bm_size_r <= sz;
              st_r <= S_SRC;
            end
            else
            begin
              bm_addr_r <= bm_rdata; // R15
              st_r <= S_INFO;
            end
          end
        end
        S_INFO:
        begin
          if (bm_ack)
          begin
            idx_r <= idx_r + 2'h1;
            if (idx_r == INFO_LAST_WORD)
            begin
              bm_addr_r <= src_ptr_r; // R2
              bm_size_r <= sz; // R17
              st_r <= S_SRC;
            end
            else
            begin
              bm_addr_r <= bm_addr_r + INFO_WORD_STEP;
            end
          end
        end
        S_SRC:
        begin
          if (bm_ack)
          begin
            bm_rd_r <= 1'b0;
            bm_wr_r <= 1'b1;
            bm_wdata_r <= bm_rdata; // R17
            bm_addr_r <= dst_ptr_r; // R3
            st_r <= S_DST;
          end
        end
        S_DST:
        begin
          if (bm_ack)
          begin
            if (md == MD_BLOCK && !block_end)
            begin
              // rest of the block moves in the same activation
              bm_wr_r <= 1'b0;
              bm_rd_r <= 1'b1; // R6
              bm_addr_r <= src_ptr_nxt;
              st_r <= S_SRC;
            end
            else
            begin
              final_r <= last_unit; // R19
              bm_addr_r <= info_base_r; // R12
              bm_size_r <= SZ_LONG;
              bm_wdata_r <= {mode_a_r, mode_b_r, cnt_a_nxt}; // R12
              idx_r <= 2'h0;
              st_r <= S_WB; // R16
            end
          end
        end
        S_WB:
        begin
          if (bm_ack)
          begin
            idx_r <= idx_r + 2'h1;
            bm_addr_r <= bm_addr_r + INFO_WORD_STEP;
            bm_wdata_r <= wb_word; // R12
            if (idx_r == INFO_LAST_WORD)
            begin
              bm_wr_r <= 1'b0;
              st_r <= S_DONE;
            end
          end
        end
        S_DONE:
        begin
          bm_req_r <= 1'b0; // R16
          st_r <= S_IDLE;
        end
        default:
        begin
          st_r <= S_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // hidden registers: loaded from RAM only, never by the cpu port
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_a_r <= 8'h0;
      mode_b_r <= 8'h0;
      src_ptr_r <= 32'h0;
      dst_ptr_r <= 32'h0;
      cnt_a_r <= 16'h0;
      blk_cnt_r <= 16'h0;
      info_ok_r <= 1'b0;
      last_src_r <= 4'h0;
    end
    else if (ce)
    begin
      if (st_r == S_INFO && bm_ack)
      begin
        case (idx_r)
          2'h0:
          begin
            mode_a_r <= bm_rdata[31:24]; // R1 R11
            mode_b_r <= bm_rdata[23:16]; // R1 R11
            cnt_a_r <= bm_rdata[15:0]; // R11
          end
          2'h1: src_ptr_r <= bm_rdata; // R11
          2'h2: dst_ptr_r <= bm_rdata; // R11
          default: blk_cnt_r <= bm_rdata[31:16]; // R11
        endcase
      end
      if (st_r == S_DST && bm_ack)
      begin
        src_ptr_r <= src_ptr_nxt; // R22
        dst_ptr_r <= dst_ptr_nxt; // R16
        cnt_a_r <= cnt_a_nxt;
        blk_cnt_r <= blk_cnt_nxt;
      end
      if (st_r == S_DONE)
      begin
        info_ok_r <= 1'b1;
        last_src_r <= cur_src_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cpu register file; the final-transfer clear beats a same-cycle write
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      act_en_r <= RST_ACT_EN;
      ctrl_r <= RST_CTRL;
      vbase_r <= RST_VBASE;
    end
    else if (ce)
    begin
      if (reg_wr && reg_addr == OFF_ACT_EN)
      begin
        act_en_r <= reg_wdata[15:0]; // R8
      end
      if (reg_wr && reg_addr == OFF_CTRL)
      begin
        ctrl_r <= reg_wdata[7:0]; // R9
      end
      if (reg_wr && reg_addr == OFF_VBASE)
      begin
        vbase_r <= reg_wdata; // R10
      end
      if (st_r == S_DONE && final_r)
      begin
        act_en_r[cur_src_r] <= 1'b0; // R19
      end
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata_r <= 32'h0;
    end
    else if (ce)
    begin
      reg_rdata_r <= 32'h0;
      if (reg_rd)
      begin
        case (reg_addr)
          OFF_ACT_EN: reg_rdata_r <= {16'h0, act_en_r};
          OFF_CTRL: reg_rdata_r <= {24'h0, ctrl_r};
          OFF_VBASE: reg_rdata_r <= vbase_r;
          OFF_STATUS:
          begin
            reg_rdata_r[STAT_BUSY_BIT] <= (st_r != S_IDLE);
            reg_rdata_r[STAT_SRC_LSB +: 4] <= cur_src_r;
          end
          default: reg_rdata_r <= 32'h0;
        endcase
      end
    end
  end

  // enabled sources are withheld from the cpu; cleared enables pass through
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cpu_irq_r <= 16'h0;
    end
    else if (ce)
    begin
      cpu_irq_r <= irq_in & ~act_en_r; // R14 R19
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks; they assume ce stays high across the cycles they span
  vec_addr_a: assert property (@(posedge core_clk) disable iff (!rst_n || !ce) // R13
    (st_r == S_GRANT && bm_gnt) |=> (bm_addr_r == vbase_r + 32'h400 + {22'h0, vec_num, 2'b00}))
    else $error("vector entry address wrong");
  bus_order_a: assert property (@(posedge core_clk) disable iff (!rst_n || !ce) // R15
    (bm_rd_r || bm_wr_r) |-> bm_req_r)
    else $error("bus access without mastership");
  load_info_a: assert property (@(posedge core_clk) disable iff (!rst_n || !ce) // R11
    (st_r == S_INFO && bm_ack && idx_r == 2'h1) |=> (src_ptr_r == $past(bm_rdata)))
    else $error("source pointer not loaded from RAM");
  wb_content_a: assert property (@(posedge core_clk) disable iff (!rst_n || !ce) // R12
    (st_r == S_WB && idx_r == 2'h1) |-> (bm_wdata_r == src_ptr_r && bm_wr_r))
    else $error("writeback word holds wrong pointer");
  release_late_a: assert property (@(posedge core_clk) disable iff (!rst_n || !ce) // R16
    $fell(bm_req_r) |-> ($past(st_r) == S_DONE && !bm_wr_r))
    else $error("bus released before writeback");
  withhold_irq_a: assert property (@(posedge core_clk) disable iff (!rst_n || !ce) // R14
    take |=> !cpu_irq_r[cur_src_r])
    else $error("enabled request reached the cpu");
  normal_count_a: assert property (@(posedge core_clk) disable iff (!rst_n || !ce) // R23
    (st_r == S_DST && bm_ack && md == MD_NORMAL) |=> (cnt_a_r == $past(cnt_a_r) - 16'h1))
    else $error("normal counter not decremented");
  final_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n || !ce) // R19
    (st_r == S_DONE && final_r) |=> !act_en_r[$past(cur_src_r)])
    else $error("enable not cleared after final transfer");
  no_overlap_a: assert property (@(posedge core_clk) disable iff (!rst_n || !ce) // R24
    (st_r != S_IDLE && st_r != S_DONE) |=> (cur_src_r == $past(cur_src_r)))
    else $error("second activation overlapped");
  dst_step_a: assert property (@(posedge core_clk) disable iff (!rst_n || !ce) // R22
    (st_r == S_DST && bm_ack && mode_b_r[MB_DAM_LSB +: 2] == AM_INC)
    |=> (dst_ptr_r - $past(dst_ptr_r) == (32'h1 << sz)))
    else $error("destination pointer step wrong");

endmodule : edtc_top

/* tb/edtc_bus_model.sv */
/*
  Far side model: grants the bus, answers each access from a sparse memory
  and stands in for the converter that raises the conversion end request.
  Assumes the controller holds each strobe until it sees bm_ack.
*/
`timescale 1ns/1ps
module edtc_bus_model
(
  input wire logic core_clk, // system clock
  input wire logic rst_n, // bench reset, active low
  input wire logic slow, // add three wait cycles after each ack
  input wire logic conv_done, // converter finished a conversion
  input wire logic bm_req, // mastership request
  output logic bm_gnt, // mastership grant
  input wire logic bm_rd, // read strobe
  input wire logic bm_wr, // write strobe
  input wire logic [31:0] bm_addr, // access address
  input wire logic [31:0] bm_wdata, // write data
  output logic [31:0] bm_rdata, // read data
  output logic bm_ack, // access done
  output logic conv_flag // conversion end request level
);
  localparam logic [31:0] RESULT_ADDR = 32'hffff_0000;
  logic [31:0] mem [logic [31:0]];
  logic [1:0] wait_r;
  //////////////////////////////////////////////////////////////////////////
  // read data toggles between acks so a stale value is never taken for fresh
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bm_gnt <= 1'b0;
      bm_ack <= 1'b0;
      bm_rdata <= 32'h0;
      wait_r <= 2'h0;
      conv_flag <= 1'b0;
    end
    else
    begin
      bm_gnt <= bm_req;
      bm_ack <= 1'b0;
      bm_rdata <= ~bm_rdata;
      if ((bm_rd || bm_wr) && !bm_ack)
      begin
        if (wait_r != 2'h0)
          wait_r <= wait_r - 2'h1;
        else
        begin
          bm_ack <= 1'b1;
          wait_r <= {slow, slow};
          if (bm_rd)
            bm_rdata <= mem.exists(bm_addr) ? mem[bm_addr] : 32'h0;
          if (bm_wr)
            mem[bm_addr] = bm_wdata;
          if (bm_rd && bm_addr == RESULT_ADDR)
            conv_flag <= 1'b0;
        end
      end
      if (conv_done)
        conv_flag <= 1'b1;
    end
  end
endmodule : edtc_bus_model

/* tb/edtc_top_tb_top.sv */
/*
  Self-checking bench for the transfer controller: register port, two
  normal-mode activations, one block and the hand-back of the request to the CPU.
  Assumes the far side model in edtc_bus_model.
*/
`timescale 1ns/1ps
module edtc_top_tb_top;
  import edtc_pkg::*;
  logic core_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0;
  logic conv_done = 1'b0, bm_req, bm_gnt, bm_rd, bm_wr, bm_ack, conv_flag, leak = 1'b0;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, bm_addr, bm_wdata, bm_rdata, rd_val;
  logic [31:0] acc_addr [0:1];
  logic [15:0] cpu_irq;
  logic [1:0] bm_size, size_seen;
  int bad_count = 0, checked = 0, acks = 0, cyc = 0;
  edtc_top edtc_top_i (.core_clk(core_clk), .nrst(nrst), .ce(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq_in({15'h0, conv_flag}), .cpu_irq(cpu_irq), .bm_req(bm_req), .bm_gnt(bm_gnt),
    .bm_rd(bm_rd), .bm_wr(bm_wr), .bm_addr(bm_addr), .bm_size(bm_size),
    .bm_wdata(bm_wdata), .bm_rdata(bm_rdata), .bm_ack(bm_ack));
  edtc_bus_model edtc_bus_model_i (.core_clk(core_clk), .rst_n(nrst), .slow(slow),
    .conv_done(conv_done), .bm_req(bm_req), .bm_gnt(bm_gnt), .bm_rd(bm_rd),
    .bm_wr(bm_wr), .bm_addr(bm_addr), .bm_wdata(bm_wdata), .bm_rdata(bm_rdata),
    .bm_ack(bm_ack), .conv_flag(conv_flag));
  //////////////////////////////////////////////////////////////////////////
  // clock, hang limit and bus monitor
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cyc++;
    if (bm_ack === 1'b1 && acks < 2)
      acc_addr[acks] = bm_addr;
    if (bm_ack === 1'b1 && acks == 5)
      size_seen = bm_size;
    if (bm_ack === 1'b1)
      acks++;
    if (cpu_irq[0] === 1'b1)
      leak = 1'b1;
    if (cyc == 3000)
    begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic print_verdict();
    if (bad_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  //////////////////////////////////////////////////////////////////////////
  // register port master: one-cycle strobes, read data in the next cycle
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [7:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask : reg_read
  //////////////////////////////////////////////////////////////////////////
  // reset values, read back, unmapped place
  task automatic t_regs();
    reg_read(OFF_ACT_EN);
    chk("act_en reset", {16'h0, RST_ACT_EN}, rd_val);
    reg_read(OFF_CTRL);
    chk("ctrl reset", {24'h0, RST_CTRL}, rd_val);
    reg_write(OFF_VBASE, 32'h0000_1000);
    reg_read(OFF_VBASE);
    chk("vbase", 32'h0000_1000, rd_val);
    reg_read(8'h20);
    chk("unmapped", 32'h0, rd_val);
  endtask : t_regs
  // one activation: conversion ends, whole sequence runs and bus is let go
  task automatic activate(input int acks_exp, input logic [1:0] usz);
    int n;
    acks = 0;
    @(posedge core_clk);
    conv_done <= 1'b1;
    @(posedge core_clk);
    conv_done <= 1'b0;
    n = 0;
    while (bm_req !== 1'b1 && n < 20)
    begin
      @(posedge core_clk);
      n++;
    end
    while (bm_req !== 1'b0 && n < 300)
    begin
      @(posedge core_clk);
      n++;
    end
    chk("ack count", acks_exp, acks);
    chk("unit size", {30'h0, usz}, {30'h0, size_seen});
    chk("vector addr", 32'h0000_1500, acc_addr[0]);
    chk("info addr", 32'h0000_2000, acc_addr[1]);
    chk("flag cleared", 32'h0, {31'h0, conv_flag});
  endtask : activate
  // first of two word transfers, fixed source, incrementing destination
  task automatic t_normal();
    edtc_bus_model_i.mem[32'h0000_1500] = 32'h0000_2000;
    edtc_bus_model_i.mem[32'h0000_2000] = {8'h10, 8'h08, 16'h0002};
    edtc_bus_model_i.mem[32'h0000_2004] = 32'hffff_0000;
    edtc_bus_model_i.mem[32'h0000_2008] = 32'h0000_3000;
    edtc_bus_model_i.mem[32'h0000_200c] = 32'h0;
    edtc_bus_model_i.mem[32'hffff_0000] = 32'h0000_0abc;
    reg_write(OFF_ACT_EN, 32'h0000_0001);
    activate(11, SZ_WORD);
    chk("data moved", 32'h0000_0abc, edtc_bus_model_i.mem[32'h0000_3000]);
    chk("count wb", {8'h10, 8'h08, 16'h0001}, edtc_bus_model_i.mem[32'h0000_2000]);
    chk("dst wb", 32'h0000_3002, edtc_bus_model_i.mem[32'h0000_2008]);
    chk("src wb", 32'hffff_0000, edtc_bus_model_i.mem[32'h0000_2004]);
    reg_read(OFF_ACT_EN);
    chk("enable kept", 32'h1, rd_val);
  endtask : t_normal
  // final transfer with a slow bus, then the request goes to the CPU
  task automatic t_final();
    slow <= 1'b1;
    edtc_bus_model_i.mem[32'hffff_0000] = 32'h0000_0def;
    activate(11, SZ_WORD);
    chk("data 2", 32'h0000_0def, edtc_bus_model_i.mem[32'h0000_3002]);
    chk("no cpu irq", 32'h0, {31'h0, leak});
    reg_read(OFF_ACT_EN);
    chk("enable cleared", 32'h0, rd_val);
    @(posedge core_clk);
    conv_done <= 1'b1;
    @(posedge core_clk);
    conv_done <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk("cpu irq", 32'h1, {31'h0, cpu_irq[0]});
    chk("bus idle", 32'h0, {31'h0, bm_req});
  endtask : t_final
  // one block of two longwords from a fixed source; pending request starts it
  task automatic t_block();
    edtc_bus_model_i.mem[32'h0000_2000] = {8'ha0, 8'h08, 16'h0202};
    edtc_bus_model_i.mem[32'h0000_2008] = 32'h0000_5000;
    edtc_bus_model_i.mem[32'h0000_200c] = 32'h0001_0000;
    reg_write(OFF_ACT_EN, 32'h0000_0001);
    activate(13, SZ_LONG);
    chk("block 2nd", 32'h0000_0def, edtc_bus_model_i.mem[32'h0000_5004]);
    chk("block wb", {8'ha0, 8'h08, 16'h0202}, edtc_bus_model_i.mem[32'h0000_2000]);
    chk("blocks wb", 32'h0, edtc_bus_model_i.mem[32'h0000_200c]);
    chk("block dst", 32'h0000_5008, edtc_bus_model_i.mem[32'h0000_2008]);
    reg_read(OFF_ACT_EN);
    chk("block end", 32'h0, rd_val);
  endtask : t_block
  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (5) @(posedge core_clk);
    t_regs();
    t_normal();
    t_final();
    t_block();
    print_verdict();
  end
endmodule : edtc_top_tb_top
